// ==== rtl/power_sleep_control.v ====
// power sequencing, sleep control and host channel latch for the module
//
// Summary of operation
// - toggle low 800 ms while off powers on
// - power-on sequence about 5 s, then ready
// - toggle low 2 s starts 8 s power-off
// - toggle off only after 10 s since ready
// - key level high powers on, stays active
// - key level low starts 30 s power-off
// - sleep delay 1..4 s, zero disables sleep
// - never sleep while usb channel selected
// - no sleep on serial activity; idle delay
// - asleep: clear-to-send blinks in 500 ms halves
// - wake input low keeps device awake
// - host wake low before, during sending
// - bus-power sampled at power-up picks channel
// - channel fixed; never both channels at once
// - serial flow: hardware, xon/xoff, or none
// - power inputs watched even while off
`include "pwr_seq_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module power_sleep_control #(
  parameter [31:0] ON_PULSE_CYC  = `ON_PULSE_MIN_MS * `MS_CYC,
  parameter [31:0] OFF_PULSE_CYC = `OFF_PULSE_MIN_MS * `MS_CYC,
  parameter [31:0] LOCKOUT_CYC   = `LOCKOUT_MS * `MS_CYC,
  parameter [31:0] PON_SEQ_CYC   = `PWR_ON_SEQ_MS * `MS_CYC,
  parameter [31:0] POFF_SEQ_CYC  = `PWR_OFF_SEQ_MS * `MS_CYC,
  parameter [31:0] KOFF_SEQ_CYC  = `KEY_OFF_SEQ_MS * `MS_CYC,
  parameter [31:0] WAKE_LEAD_CYC = `WAKE_LEAD_MS * `MS_CYC,
  parameter [31:0] BLINK_CYC     = `BLINK_HALF_MS * `MS_CYC,
  parameter [31:0] SEC_CYC       = `SEC_MS * `MS_CYC
) (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        pwr_toggle_n,
  input  wire        key_level,
  input  wire        wake_req_n,
  input  wire        usb_vbus,
  input  wire        ser_txd_act,
  input  wire        ser_rxd_act,
  input  wire        tx_buf_empty,
  input  wire        host_data_pend,
  input  wire [3:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr_stb,
  input  wire        rd_stb,
  output reg  [7:0]  rdata,
  output reg         powered,
  output reg         ready,
  output reg         asleep,
  output reg         cts,
  output reg         host_wake_n,
  output reg         send_go,
  output reg         wake_irq,
  output reg         usb_sel,
  output reg         usb_en,
  output reg         ser_en,
  output reg  [1:0]  flow_mode
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg [5:0] s1_r;
  reg [5:0] s2_r;
  // pins are asynchronous to core_clk; two stages before use
  // reset to the idle pin levels: toggle high, key low, wake high,
  // no bus power, no serial activity; all ones would read as a key
  // press and power the unit up at the first edge after reset
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= `SYNC_IDLE;
      s2_r <= `SYNC_IDLE;
    end else begin
      s1_r <= {pwr_toggle_n, key_level, wake_req_n, usb_vbus,
               ser_txd_act, ser_rxd_act};
      s2_r <= s1_r;
    end
  end
  wire tog_n  = s2_r[5];
  wire key    = s2_r[4];
  wire wake_n = s2_r[3];
  wire vbus   = s2_r[2];
  wire ser_act = s2_r[1] | s2_r[0];

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  localparam [2:0] ST_OFF    = 3'h0;
  localparam [2:0] ST_PON    = 3'h1;
  localparam [2:0] ST_RUN    = 3'h2;
  localparam [2:0] ST_POFF   = 3'h3;
  localparam [2:0] ST_RELEAS = 3'h4;

  reg [2:0]  st_r;
  reg [31:0] seq_cnt_r;
  reg [31:0] low_cnt_r;
  reg [31:0] lock_cnt_r;
  reg        key_mode_r;
  wire       lock_done = (lock_cnt_r >= LOCKOUT_CYC);
  // an off request that the sequencer takes in this cycle; the channel
  // enables drop on the same edge as ready so they never outlive it
  wire       off_req   = (st_r == ST_RUN) &&
                         ((key_mode_r && !key) ||
                          (!key_mode_r && lock_done &&
                           low_cnt_r >= OFF_PULSE_CYC));

  // pulse width of toggle low; runs in every state, even off
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      low_cnt_r <= 32'h0000_0000;
    else if (tog_n)
      low_cnt_r <= 32'h0000_0000;
    else if (low_cnt_r != 32'hffff_ffff)
      low_cnt_r <= low_cnt_r + 32'h0000_0001;
  end

  // main sequencer; toggle-off needs release before re-arming
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r       <= ST_OFF;
      seq_cnt_r  <= 32'h0000_0000;
      lock_cnt_r <= 32'h0000_0000;
      key_mode_r <= 1'b0;
      powered    <= 1'b0;
      ready      <= 1'b0;
    end else begin
      if (st_r == ST_RUN && !lock_done)
        lock_cnt_r <= lock_cnt_r + 32'h0000_0001;
      case (st_r)
        ST_OFF: begin
          if (key) begin
            st_r <= ST_PON;
            key_mode_r <= 1'b1;
            powered <= 1'b1;
            seq_cnt_r <= 32'h0000_0000;
          end else if (low_cnt_r >= ON_PULSE_CYC) begin
            st_r <= ST_PON;
            key_mode_r <= 1'b0;
            powered <= 1'b1;
            seq_cnt_r <= 32'h0000_0000;
          end
        end
        ST_PON: begin
          if (seq_cnt_r >= PON_SEQ_CYC - 32'h0000_0001) begin
            st_r <= ST_RUN;
            ready <= 1'b1;
            lock_cnt_r <= 32'h0000_0000;
          end else
            seq_cnt_r <= seq_cnt_r + 32'h0000_0001;
        end
        ST_RUN: begin
          if (key_mode_r && !key) begin
            st_r <= ST_POFF;
            ready <= 1'b0;
            seq_cnt_r <= 32'h0000_0000;
          end else if (!key_mode_r && lock_done &&
                       low_cnt_r >= OFF_PULSE_CYC) begin
            st_r <= ST_POFF;
            ready <= 1'b0;
            seq_cnt_r <= 32'h0000_0000;
          end
        end
        ST_POFF: begin
          // key-driven shutdown has the longer budget
          if (seq_cnt_r >= (key_mode_r ? KOFF_SEQ_CYC : POFF_SEQ_CYC)
                           - 32'h0000_0001) begin
            st_r <= ST_RELEAS;
            powered <= 1'b0;
          end else
            seq_cnt_r <= seq_cnt_r + 32'h0000_0001;
        end
        ST_RELEAS: begin
          // avoid an off-hold re-triggering power-on at once
          if (tog_n && !key)
            st_r <= ST_OFF;
        end
        default: st_r <= ST_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // channel latch at power-up
  // ----------------------------------------------------------------
  // bus power is followed only while off, so the channel cannot move
  // during a powered session; enables come one cycle after ready and
  // leave together with it
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      usb_sel <= 1'b0;
      usb_en  <= 1'b0;
      ser_en  <= 1'b0;
    end else begin
      if (st_r == ST_OFF)
        usb_sel <= vbus;
      usb_en <= ready & ~off_req & usb_sel;
      ser_en <= ready & ~off_req & ~usb_sel;
    end
  end

  // ----------------------------------------------------------------
  // register port: ctrl holds sleep delay and flow mode
  // ----------------------------------------------------------------
  // out-of-range fields are dropped one by one, so a bad sleep delay
  // does not stop a good flow mode from landing in the same write
  reg [2:0] sleep_dly_r;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sleep_dly_r <= 3'h0;
      flow_mode   <= `FLOW_HW;
      rdata       <= 8'h00;
    end else begin
      if (wr_stb && addr == `ADDR_CTRL) begin
        if (wdata[2:0] <= `SLEEP_DLY_MAX)
          sleep_dly_r <= wdata[2:0];
        if (wdata[5:4] != 2'h3)
          flow_mode <= wdata[5:4];
      end
      if (rd_stb && addr == `ADDR_CTRL)
        rdata <= {2'h0, flow_mode, 1'b0, sleep_dly_r};
      else if (rd_stb && addr == `ADDR_STATUS)
        rdata <= {1'b0, usb_sel, ~host_wake_n, asleep, ready, powered,
                  st_r == ST_POFF, st_r == ST_PON};
      else
        rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // sleep control
  // ----------------------------------------------------------------
  reg [31:0] idle_cnt_r;
  reg [31:0] blink_cnt_r;
  reg        blink_r;
  reg        wake_d_r;
  wire busy = ser_act | ~tx_buf_empty | ~wake_n | host_data_pend
              | ~host_wake_n;
  // idle time restarts on any activity, so a trickle of traffic keeps
  // the unit awake indefinitely; the blink runs only while asleep
  wire idle_done = idle_cnt_r >= SEC_CYC * {29'h0, sleep_dly_r};
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt_r  <= 32'h0000_0000;
      asleep      <= 1'b0;
      blink_cnt_r <= 32'h0000_0000;
      blink_r     <= 1'b0;
      wake_d_r    <= 1'b1;
      wake_irq    <= 1'b0;
      cts         <= 1'b0;
    end else begin
      wake_d_r <= wake_n;
      wake_irq <= wake_d_r & ~wake_n;
      if (!ready || usb_sel || sleep_dly_r == 3'h0 || busy) begin
        idle_cnt_r <= 32'h0000_0000;
        asleep <= 1'b0;
      end else if (idle_done)
        asleep <= 1'b1;
      else
        idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
      if (!asleep || blink_cnt_r >= BLINK_CYC - 32'h0000_0001) begin
        blink_cnt_r <= 32'h0000_0000;
        blink_r <= asleep & ~blink_r;
      end else
        blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
      // awake level whenever ser_en, any flow mode; blink pattern while asleep
      cts <= ser_en & (asleep ? blink_r : 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // host wake: lead time, then sending until data is done
  // ----------------------------------------------------------------
  // dropping the pending flag releases both outputs at once; a new
  // request always pays the full lead time again
  reg [31:0] lead_cnt_r;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lead_cnt_r  <= 32'h0000_0000;
      host_wake_n <= 1'b1;
      send_go     <= 1'b0;
    end else if (!ready || !host_data_pend) begin
      lead_cnt_r  <= 32'h0000_0000;
      host_wake_n <= 1'b1;
      send_go     <= 1'b0;
    end else begin
      host_wake_n <= 1'b0;
      if (lead_cnt_r >= WAKE_LEAD_CYC - 32'h0000_0001)
        send_go <= 1'b1;
      else
        lead_cnt_r <= lead_cnt_r + 32'h0000_0001;
    end
  end

endmodule // power_sleep_control
`default_nettype wire

// ==== rtl/pwr_seq_consts.vh ====
// timing, setting and encoding constants for the power and sleep sequencer
`ifndef PWR_SEQ_CONSTS_VH
`define PWR_SEQ_CONSTS_VH
`define CLK_HZ              40000000
`define ON_PULSE_MIN_MS     800
`define OFF_PULSE_MIN_MS    2000
`define LOCKOUT_MS          10000
`define PWR_ON_SEQ_MS       5000
`define PWR_OFF_SEQ_MS      8000
`define KEY_OFF_SEQ_MS      30000
`define WAKE_LEAD_MS        30
`define BLINK_HALF_MS       500
`define MS_CYC              (`CLK_HZ / 1000)
`define SLEEP_DLY_MAX       3'h4
`define SEC_MS              1000
`define SYNC_IDLE           6'h28
`define ADDR_CTRL           4'h0
`define ADDR_STATUS         4'h1
`define FLOW_NONE           2'h0
`define FLOW_HW             2'h1
`define FLOW_XON            2'h2
`endif

// ==== testbench/host_model.sv ====
// host terminal model driving the power and wake inputs
`timescale 1ns/1ps
`default_nettype none
module host_model (
  output var logic pwr_toggle_n,
  output var logic key_level,
  output var logic wake_req_n,
  input wire logic core_clk
);
  initial begin
    pwr_toggle_n = 1'b1;
    key_level = 1'b0;
    wake_req_n = 1'b1;
  end
  // held low the whole count; a short count probes the filter
  task press(input int n);
    @(posedge core_clk) pwr_toggle_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    pwr_toggle_n <= 1'b1;
  endtask
  // key held at its level until changed, off included
  task set_key(input logic v);
    @(posedge core_clk) key_level <= v;
  endtask
  // wake held low through the whole transfer
  task wake(input logic v);
    @(posedge core_clk) wake_req_n <= v;
  endtask
endmodule // host_model
`default_nettype wire

// ==== testbench/power_sleep_control_checker.sv ====
// checker for the power, sleep and channel outputs of the sequencer
`timescale 1ns/1ps
`default_nettype none
module power_sleep_control_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wake_req_n,
  input wire logic host_data_pend,
  input wire logic powered,
  input wire logic ready,
  input wire logic asleep,
  input wire logic host_wake_n,
  input wire logic send_go,
  input wire logic wake_irq,
  input wire logic usb_sel,
  input wire logic usb_en,
  input wire logic ser_en
);
  // one clock domain, reset silences every check
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_excl; !(usb_en && ser_en); endproperty
  a_excl: assert property (p_excl) else $error("both channels on");
  property p_chan; powered && $past(powered) |-> $stable(usb_sel); endproperty
  a_chan: assert property (p_chan) else $error("channel moved");
  property p_usb_awake; usb_sel |-> !asleep; endproperty
  a_usb_awake: assert property (p_usb_awake) else $error("usb sleep");
  property p_en_ready; (usb_en || ser_en) |-> ready; endproperty
  a_en_ready: assert property (p_en_ready) else $error("early chan");
  // ready may only follow a long stretch of power
  property p_late; $rose(ready) |-> $past(powered, 40); endproperty
  a_late: assert property (p_late) else $error("ready too soon");
  property p_wout; host_data_pend && ready |=> !host_wake_n; endproperty
  a_wout: assert property (p_wout) else $error("wake out high");
  property p_lead; $rose(send_go) |-> $past(host_wake_n, 4) == 1'b0;
  endproperty
  a_lead: assert property (p_lead) else $error("no lead time");
  // sync delay allowed before the wake input takes hold
  property p_awake; !wake_req_n [*4] |-> !asleep; endproperty
  a_awake: assert property (p_awake) else $error("slept on wake");
  property p_irq; wake_irq |=> !wake_irq; endproperty
  a_irq: assert property (p_irq) else $error("long irq");
endmodule // power_sleep_control_checker
`default_nettype wire

// ==== testbench/test_power_sleep_control.sv ====
// self-checking bench for the power and sleep sequencer
`include "pwr_seq_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module test_power_sleep_control;
  logic       core_clk, resetn, pwr_toggle_n, key_level, wake_req_n, c, seen;
  logic       usb_vbus, ser_txd_act, ser_rxd_act, tx_buf_empty, host_data_pend;
  logic       wr_stb, rd_stb, powered, ready, asleep, cts, host_wake_n;
  logic       send_go, wake_irq, usb_sel, usb_en, ser_en;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [1:0] flow_mode;
  int         err_count, tests_run, i;
  // ctrl write value beside the readback it should leave
  logic [15:0] rows [6] = '{16'h0000, 16'h0101, 16'h1414, 16'h2424,
                            16'h3524, 16'h1313};
  wire  [5:0] mon = {send_go, asleep, usb_en, ser_en, ready, powered};
  power_sleep_control #(.ON_PULSE_CYC(8), .OFF_PULSE_CYC(20),
    .LOCKOUT_CYC(100), .PON_SEQ_CYC(50), .POFF_SEQ_CYC(80),
    .KOFF_SEQ_CYC(300), .WAKE_LEAD_CYC(5), .BLINK_CYC(4), .SEC_CYC(10))
  DUT (.core_clk(core_clk), .resetn(resetn), .pwr_toggle_n(pwr_toggle_n),
    .key_level(key_level), .wake_req_n(wake_req_n), .usb_vbus(usb_vbus),
    .ser_txd_act(ser_txd_act), .ser_rxd_act(ser_rxd_act),
    .tx_buf_empty(tx_buf_empty), .host_data_pend(host_data_pend),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .powered(powered), .ready(ready), .asleep(asleep),
    .cts(cts), .host_wake_n(host_wake_n), .send_go(send_go),
    .wake_irq(wake_irq), .usb_sel(usb_sel), .usb_en(usb_en),
    .ser_en(ser_en), .flow_mode(flow_mode));
  host_model hm (.pwr_toggle_n(pwr_toggle_n), .key_level(key_level),
    .wake_req_n(wake_req_n), .core_clk(core_clk));
  task chk(input logic [7:0] exp, input logic [7:0] got, input string nm);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task stop_test;
    $display("mismatches %0d comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // lands past the edge so registered outputs have settled
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // bounded wait; running out ends the run
  task wait_bit(input int b, input logic v, input int lim, input string nm);
    for (int n = 0; n < lim && mon[b] !== v; n++) cyc(1);
    chk({7'h0, v}, {7'h0, mon[b]}, nm);
    if (mon[b] !== v) stop_test;
  endtask
  // one-cycle strobe; read data stands only in the following cycle
  task bus(input logic [3:0] a, input logic [7:0] v, input logic w);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= w;
    rd_stb <= !w;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // serial activity held on early so nothing sleeps before its test
  initial begin
    {resetn, usb_vbus, ser_txd_act, host_data_pend, wr_stb, rd_stb} = '0;
    {ser_rxd_act, tx_buf_empty, addr, wdata} = {2'b10, 12'h000};
    err_count = 0;
    tests_run = 0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    cyc(1);
    chk(8'h09, {4'h0, host_wake_n, powered, flow_mode}, "reset");
    hm.press(6);
    cyc(15);
    chk(8'h00, {7'h0, powered}, "short press");
    hm.press(12);
    wait_bit(0, 1'b1, 20, "powered");
    wait_bit(1, 1'b1, 70, "ready");
    cyc(1);
    chk(8'h01, {5'h0, usb_sel, usb_en, ser_en}, "ser chan");
    hm.press(25);
    cyc(90);
    chk(8'h01, {7'h0, powered}, "early off");
    for (i = 0; i < 6; i++) begin
      bus(`ADDR_CTRL, rows[i][15:8], 1'b1);
      bus(`ADDR_CTRL, 8'h00, 1'b0);
      chk(rows[i][7:0], d, "ctrl");
      chk({6'h0, rows[i][5:4]}, {6'h0, flow_mode}, "flow");
    end
    bus(4'h7, 8'h5a, 1'b1);
    bus(4'h7, 8'h00, 1'b0);
    chk(8'h00, d, "unmapped");
    @(posedge core_clk) host_data_pend <= 1'b1;
    cyc(1);
    chk(8'h00, {6'h0, send_go, host_wake_n}, "wake out");
    wait_bit(5, 1'b1, 8, "send_go");
    @(posedge core_clk) host_data_pend <= 1'b0;
    cyc(2);
    chk(8'h01, {6'h0, send_go, host_wake_n}, "released");
    bus(`ADDR_CTRL, 8'h11, 1'b1);
    cyc(30);
    chk(8'h00, {7'h0, asleep}, "busy");
    @(posedge core_clk) ser_rxd_act <= 1'b0;
    cyc(30);
    chk(8'h00, {7'h0, asleep}, "tx buffer");
    @(posedge core_clk) tx_buf_empty <= 1'b1;
    wait_bit(4, 1'b1, 40, "asleep");
    c = cts;
    seen = 1'b0;
    for (i = 0; i < 10; i++) begin
      cyc(1);
      seen = seen | (cts !== c);
    end
    chk(8'h01, {7'h0, seen}, "blink");
    hm.wake(1'b0);
    wait_bit(4, 1'b0, 8, "awake");
    @(posedge core_clk) ser_txd_act <= 1'b1;
    cyc(40);
    chk(8'h00, {7'h0, asleep}, "held awake");
    @(posedge core_clk) ser_txd_act <= 1'b0;
    hm.wake(1'b1);
    hm.press(25);
    wait_bit(0, 1'b0, 120, "off");
    @(posedge core_clk) usb_vbus <= 1'b1;
    hm.press(12);
    wait_bit(1, 1'b1, 80, "usb ready");
    bus(`ADDR_CTRL, 8'h11, 1'b1);
    @(posedge core_clk) usb_vbus <= 1'b0;
    cyc(40);
    chk(8'h06, {4'h0, asleep, usb_sel, usb_en, ser_en}, "usb");
    cyc(60);
    hm.press(25);
    wait_bit(0, 1'b0, 120, "usb off");
    hm.set_key(1'b1);
    wait_bit(1, 1'b1, 80, "key ready");
    cyc(150);
    chk(8'h01, {7'h0, powered}, "key held");
    hm.set_key(1'b0);
    wait_bit(0, 1'b0, 400, "key off");
    stop_test;
  end
endmodule // test_power_sleep_control
bind power_sleep_control power_sleep_control_checker chk_i (
  .core_clk(core_clk), .resetn(resetn), .wake_req_n(wake_req_n),
  .host_data_pend(host_data_pend), .powered(powered), .ready(ready),
  .asleep(asleep), .host_wake_n(host_wake_n), .send_go(send_go),
  .wake_irq(wake_irq), .usb_sel(usb_sel), .usb_en(usb_en),
  .ser_en(ser_en));
`default_nettype wire
